// File: std_timer_pkg.sv
// Package with constants and types for the standard timer operating-mode block.
package std_timer_pkg;

  // Mode selector codes.
  localparam logic [1:0] MODE_COMPARE = 2'h0;
  localparam logic [1:0] MODE_CAPTURE = 2'h1;
  localparam logic [1:0] MODE_PWM     = 2'h2;
  localparam logic [1:0] MODE_TIMER   = 2'h3;

  // Output function codes.
  localparam logic [1:0] OUTFN_NONE   = 2'h0;
  localparam logic [1:0] OUTFN_LOW    = 2'h1;
  localparam logic [1:0] OUTFN_HIGH   = 2'h2;
  localparam logic [1:0] OUTFN_TOGGLE = 2'h3;
  localparam logic [1:0] OUTFN_INACT  = 2'h0;
  localparam logic [1:0] OUTFN_ACT    = 2'h1;
  localparam logic [1:0] OUTFN_PWM    = 2'h2;
  localparam logic [1:0] OUTFN_PULSE  = 2'h3;

  // Register byte addresses on the AXI4-Lite bus.
  localparam logic [7:0] ADDR_CONTROL   = 8'h00;
  localparam logic [7:0] ADDR_COMPARE_A = 8'h04;
  localparam logic [7:0] ADDR_PERIOD    = 8'h08;
  localparam logic [7:0] ADDR_COUNTER   = 8'h0c;
  localparam logic [7:0] ADDR_STATUS    = 8'h10;

  // Control register field positions.
  localparam int CTL_CCLR_BIT = 0;
  localparam int CTL_DPX_BIT  = 1;
  localparam int CTL_POL_BIT  = 2;
  localparam int CTL_OC_BIT   = 3;
  localparam int CTL_IO_LSB   = 4;
  localparam int CTL_M_LSB    = 6;
  localparam int CTL_RUN_BIT  = 8;

  // Status register field positions (AF and PF write one to clear).
  localparam int STS_AF_BIT   = 0;
  localparam int STS_PF_BIT   = 1;
  localparam int STS_PIN_BIT  = 2;

  // Reset values.
  localparam logic [31:0] RST_CONTROL   = 32'h0000_0000;
  localparam logic [15:0] RST_COMPARE_A = 16'h0000;
  localparam logic [7:0]  RST_PERIOD    = 8'h00;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Decoded timer control, carried as one group.
  typedef struct packed {
    logic [1:0] mode_select;
    logic [1:0] output_function;
    logic       output_initial_level;
    logic       output_invert;
    logic       duty_period_swap;
    logic       clear_source_select;
  } timer_control_one_t;

  // Write-side bus states.
  typedef enum logic [2:0] {
    WR_IDLE = 3'b001,
    WR_WAIT = 3'b010,
    WR_RESP = 3'b100
  } wr_state_t;

endpackage : std_timer_pkg

// File: standard_timer.sv
// Standard timer: compare, timer/counter, PWM and single pulse modes with AXI4-Lite registers.
`timescale 1ns/1ps
`default_nettype none

module standard_timer (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  awaddr_i,
  input  wire logic        awvalid_i,
  output logic             awready_o,
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  wstrb_i,
  input  wire logic        wvalid_i,
  output logic             wready_o,
  output logic [1:0]       bresp_o,
  output logic             bvalid_o,
  input  wire logic        bready_i,
  input  wire logic [7:0]  araddr_i,
  input  wire logic        arvalid_i,
  output logic             arready_o,
  output logic [31:0]      rdata_o,
  output logic [1:0]       rresp_o,
  output logic             rvalid_o,
  input  wire logic        rready_i,
  input  wire logic        external_trigger_pin_i,
  output logic             timer_output_pin_o,
  output logic             timer_output_pin_oe_o,
  output logic             compare_a_match_flag_o,
  output logic             period_match_flag_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations.

  std_timer_pkg::timer_control_one_t ctl;
  std_timer_pkg::wr_state_t          wr_state;
  logic        counter_run;
  logic [15:0] compare_a_value;
  logic [7:0]  period_value;
  logic [15:0] count;
  logic        run_q;
  logic        trig_q;
  logic        pin_level;
  logic        compare_a_match_flag;
  logic        period_match_flag;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        aw_held;
  logic        w_held;
  logic        wr_fire;
  logic        wr_ok;
  logic        run_rise;
  logic        is_pwm;
  logic        is_pulse;
  logic        match_a;
  logic        match_p;
  logic        clear_cnt;
  logic        set_af;
  logic        set_pf;
  logic        stop_run;
  logic        pwm_active;
  logic        next_pin_level;
  logic        next_pin_oe;
  logic [16:0] duty_len;
  logic [16:0] period_len;
  logic [31:0] ctl_merged;
  logic [31:0] cmp_merged;
  logic [31:0] per_merged;

  // Merges a write word into a stored word under byte strobes.
  function automatic logic [31:0] apply_strobe(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : apply_strobe

  // Length in clocks that a period value stands for: value times 256, zero meaning 65536.
  function automatic logic [16:0] period_clocks(input logic [7:0] pv);
    return (pv == 8'h00) ? 17'h10000 : {1'b0, pv, 8'h00};
  endfunction : period_clocks

  ////////////////////////////////////////////////////////////////////////////////
  // Timer decode.

  assign run_rise = counter_run & ~run_q;
  assign is_pwm   = (ctl.mode_select == std_timer_pkg::MODE_PWM)
                    && (ctl.output_function != std_timer_pkg::OUTFN_PULSE);
  assign is_pulse = (ctl.mode_select == std_timer_pkg::MODE_PWM)
                    && (ctl.output_function == std_timer_pkg::OUTFN_PULSE);
  // The restart cycle still shows the old count, so it must not match.
  assign match_a  = counter_run && !run_rise && (count == compare_a_value);
  // full count compare, low byte 8'hff
  // Matching on the last count of the span makes the clear give value times 256 clocks.
  assign match_p  = counter_run && !run_rise && (count == {period_value - 8'h01, 8'hff});
  assign duty_len   = is_pwm && ctl.duty_period_swap ? period_clocks(period_value)
                      : {1'b0, compare_a_value};
  assign period_len = is_pwm && ctl.duty_period_swap ? {1'b0, compare_a_value}
                      : period_clocks(period_value);

  always_comb begin
    clear_cnt = 1'b0;
    set_af    = 1'b0;
    set_pf    = 1'b0;
    stop_run  = 1'b0;
    if (is_pulse) begin
      set_af   = match_a;
      stop_run = match_a;
    end else if (is_pwm) begin
      clear_cnt = ctl.duty_period_swap ? match_a : match_p;
      set_af = match_a;
      set_pf = match_p;
    end else if (ctl.clear_source_select) begin
      clear_cnt = match_a;
      set_af    = match_a;
    end else begin
      clear_cnt = match_p;
      set_af = match_a;
      set_pf = match_p;
    end
  end

  assign pwm_active = ({1'b0, count} < duty_len) || (duty_len >= period_len);

  always_comb begin
    next_pin_level = pin_level;
    next_pin_oe    = 1'b1;
    unique case (ctl.mode_select)
      std_timer_pkg::MODE_COMPARE: begin
        if (run_rise) begin
          next_pin_level = ctl.output_initial_level;
        end else if (set_af) begin
          unique case (ctl.output_function)
            std_timer_pkg::OUTFN_NONE:   next_pin_level = pin_level;
            std_timer_pkg::OUTFN_LOW:    next_pin_level = 1'b0;
            std_timer_pkg::OUTFN_HIGH:   next_pin_level = 1'b1;
            std_timer_pkg::OUTFN_TOGGLE: next_pin_level = ~pin_level;
          endcase
        end
      end
      std_timer_pkg::MODE_PWM: begin
        unique case (ctl.output_function)
          std_timer_pkg::OUTFN_INACT: next_pin_level = ~ctl.output_initial_level;
          std_timer_pkg::OUTFN_ACT:   next_pin_level = ctl.output_initial_level;
          std_timer_pkg::OUTFN_PWM:
            next_pin_level = (counter_run && pwm_active) ? ctl.output_initial_level
                                                         : ~ctl.output_initial_level;
          std_timer_pkg::OUTFN_PULSE:
            next_pin_level = (counter_run && !stop_run) ? ctl.output_initial_level
                                                        : ~ctl.output_initial_level;
        endcase
      end
      default: begin
        next_pin_oe = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Timer state.

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= 16'h0000;
    end else if (run_rise) begin
      count <= 16'h0000;
    end else if (counter_run) begin
      count <= clear_cnt ? 16'h0000 : count + 16'h0001;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_q  <= 1'b0;
      trig_q <= 1'b0;
    end else begin
      run_q  <= counter_run;
      trig_q <= external_trigger_pin_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_level             <= 1'b0;
      timer_output_pin_o    <= 1'b0;
      timer_output_pin_oe_o <= 1'b0;
    end else begin
      pin_level             <= next_pin_level;
      timer_output_pin_o    <= next_pin_level ^ (ctl.output_invert & next_pin_oe);
      timer_output_pin_oe_o <= next_pin_oe;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      compare_a_match_flag   <= 1'b0;
      period_match_flag      <= 1'b0;
      compare_a_match_flag_o <= 1'b0;
      period_match_flag_o    <= 1'b0;
    end else begin
      compare_a_match_flag <= set_af | (compare_a_match_flag
        & ~(wr_ok && wr_addr == std_timer_pkg::ADDR_STATUS && wr_strb[0]
            && wr_data[std_timer_pkg::STS_AF_BIT]));
      period_match_flag <= set_pf | (period_match_flag
        & ~(wr_ok && wr_addr == std_timer_pkg::ADDR_STATUS && wr_strb[0]
            && wr_data[std_timer_pkg::STS_PF_BIT]));
      compare_a_match_flag_o <= set_af | compare_a_match_flag;
      period_match_flag_o    <= set_pf | period_match_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write side.

  assign wr_fire = (aw_held | (awvalid_i & awready_o)) & (w_held | (wvalid_i & wready_o));
  assign wr_ok   = (wr_state == std_timer_pkg::WR_WAIT) & aw_held & w_held;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_state  <= std_timer_pkg::WR_IDLE;
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      awready_o <= 1'b1;
      wready_o  <= 1'b1;
      bvalid_o  <= 1'b0;
      bresp_o   <= std_timer_pkg::RESP_OKAY;
      wr_addr   <= 8'h00;
      wr_data   <= 32'h0000_0000;
      wr_strb   <= 4'h0;
    end else begin
      if (awvalid_i && awready_o) begin
        wr_addr   <= awaddr_i;
        aw_held   <= 1'b1;
        awready_o <= 1'b0;
      end
      if (wvalid_i && wready_o) begin
        wr_data  <= wdata_i;
        wr_strb  <= wstrb_i;
        w_held   <= 1'b1;
        wready_o <= 1'b0;
      end
      unique case (wr_state)
        std_timer_pkg::WR_IDLE: begin
          if (wr_fire) begin
            wr_state <= std_timer_pkg::WR_WAIT;
          end
        end
        std_timer_pkg::WR_WAIT: begin
          bvalid_o <= 1'b1;
          bresp_o  <= (wr_addr[1:0] == 2'h0 && wr_addr <= std_timer_pkg::ADDR_STATUS)
                      ? std_timer_pkg::RESP_OKAY : std_timer_pkg::RESP_SLVERR;
          wr_state <= std_timer_pkg::WR_RESP;
        end
        std_timer_pkg::WR_RESP: begin
          if (bready_i) begin
            bvalid_o  <= 1'b0;
            aw_held   <= 1'b0;
            w_held    <= 1'b0;
            awready_o <= 1'b1;
            wready_o  <= 1'b1;
            wr_state  <= std_timer_pkg::WR_IDLE;
          end
        end
        default: wr_state <= std_timer_pkg::WR_IDLE;
      endcase
    end
  end

  assign ctl_merged = apply_strobe({24'h0, ctl}, wr_data, wr_strb);
  assign cmp_merged = apply_strobe({16'h0, compare_a_value}, wr_data, wr_strb);
  assign per_merged = apply_strobe({24'h0, period_value}, wr_data, wr_strb);

  // Registers written by software; the pulse logic may also move the run bit.
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctl             <= std_timer_pkg::RST_CONTROL[7:0];
      counter_run     <= std_timer_pkg::RST_CONTROL[std_timer_pkg::CTL_RUN_BIT];
      compare_a_value <= std_timer_pkg::RST_COMPARE_A;
      period_value    <= std_timer_pkg::RST_PERIOD;
    end else begin
      if (wr_ok && wr_addr == std_timer_pkg::ADDR_CONTROL) begin
        ctl <= ctl_merged[7:0];
      end
      if (wr_ok && wr_addr == std_timer_pkg::ADDR_COMPARE_A) begin
        compare_a_value <= cmp_merged[15:0];
      end
      if (wr_ok && wr_addr == std_timer_pkg::ADDR_PERIOD) begin
        period_value <= per_merged[7:0];
      end
      if (is_pulse && external_trigger_pin_i && !trig_q) begin
        counter_run <= 1'b1;
      end else if (stop_run) begin
        counter_run <= 1'b0;
      end else if (wr_ok && wr_addr == std_timer_pkg::ADDR_CONTROL && wr_strb[1]) begin
        counter_run <= wr_data[std_timer_pkg::CTL_RUN_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read side.

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      arready_o <= 1'b1;
      rvalid_o  <= 1'b0;
      rdata_o   <= 32'h0000_0000;
      rresp_o   <= std_timer_pkg::RESP_OKAY;
    end else if (rvalid_o) begin
      if (rready_i) begin
        rvalid_o  <= 1'b0;
        arready_o <= 1'b1;
      end
    end else if (arvalid_i && arready_o) begin
      arready_o <= 1'b0;
      rvalid_o  <= 1'b1;
      rresp_o   <= std_timer_pkg::RESP_OKAY;
      unique case (araddr_i)
        std_timer_pkg::ADDR_CONTROL:   rdata_o <= {23'h0, counter_run, ctl};
        std_timer_pkg::ADDR_COMPARE_A: rdata_o <= {16'h0, compare_a_value};
        std_timer_pkg::ADDR_PERIOD:    rdata_o <= {24'h0, period_value};
        std_timer_pkg::ADDR_COUNTER:   rdata_o <= {16'h0, count};
        std_timer_pkg::ADDR_STATUS:
          rdata_o <= {29'h0, pin_level, period_match_flag, compare_a_match_flag};
        default: begin
          rdata_o <= 32'h0000_0000;
          rresp_o <= std_timer_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

endmodule : standard_timer

`default_nettype wire

// File: standard_timer_assertions.sv
// Concurrent checks on the standard timer ports.
`timescale 1ns/1ps
`default_nettype none
module standard_timer_assertions (
  input wire logic        mclk_i,
  input wire logic        rst_n_i,
  input wire logic [7:0]  awaddr_i,
  input wire logic        awvalid_i,
  input wire logic        awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0]  wstrb_i,
  input wire logic        wvalid_i,
  input wire logic        wready_o,
  input wire logic [1:0]  bresp_o,
  input wire logic        bvalid_o,
  input wire logic        bready_i,
  input wire logic [7:0]  araddr_i,
  input wire logic        arvalid_i,
  input wire logic        arready_o,
  input wire logic [31:0] rdata_o,
  input wire logic [1:0]  rresp_o,
  input wire logic        rvalid_o,
  input wire logic        rready_i,
  input wire logic        external_trigger_pin_i,
  input wire logic        timer_output_pin_o,
  input wire logic        timer_output_pin_oe_o,
  input wire logic        compare_a_match_flag_o,
  input wire logic        period_match_flag_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  a_write_answer: assert property (awvalid_i && awready_o && wvalid_i && wready_o
    |-> ##[2:3] bvalid_o) else $error("write answer late");
  a_read_answer: assert property (arvalid_i && arready_o |-> ##[1:2] rvalid_o)
    else $error("read answer late");
  a_bresp_hold: assert property (bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o))
    else $error("write response dropped");
  a_rdata_hold: assert property (rvalid_o && !rready_i
    |=> rvalid_o && $stable(rdata_o) && $stable(rresp_o)) else $error("read data dropped");
  a_write_busy: assert property (bvalid_o |-> !awready_o && !wready_o)
    else $error("write ready while busy");
  a_read_busy: assert property (rvalid_o |-> !arready_o) else $error("read ready while busy");
  a_aflag_sticky: assert property ($fell(compare_a_match_flag_o)
    |-> bvalid_o || $past(bvalid_o)) else $error("compare flag cleared without write");
  a_pflag_sticky: assert property ($fell(period_match_flag_o)
    |-> bvalid_o || $past(bvalid_o)) else $error("period flag cleared without write");
  cover property (compare_a_match_flag_o && period_match_flag_o);
  cover property ($rose(timer_output_pin_o));
  cover property (bvalid_o && bresp_o == std_timer_pkg::RESP_SLVERR);
endmodule : standard_timer_assertions
`default_nettype wire

// File: trigger_source.sv
// Model of the external trigger source feeding the timer.
`timescale 1ns/1ps
`default_nettype none
module trigger_source (
  input  wire logic mclk_i,
  input  wire logic fire_i,
  output logic      pin_o
);
  logic [2:0] width = 3'h0;
  always_ff @(posedge mclk_i) begin
    if (fire_i) width <= 3'h4;
    else if (width != 3'h0) width <= width - 3'h1;
  end
  assign pin_o = (width != 3'h0);
endmodule : trigger_source
`default_nettype wire

// File: standard_timer_tb.sv
// Self-checking testbench for the standard timer.
`timescale 1ns/1ps
`default_nettype none
module standard_timer_tb;
  localparam logic [7:0] A_CTL = std_timer_pkg::ADDR_CONTROL;
  localparam logic [7:0] A_CMP = std_timer_pkg::ADDR_COMPARE_A;
  localparam logic [7:0] A_PER = std_timer_pkg::ADDR_PERIOD;
  localparam logic [7:0] A_STS = std_timer_pkg::ADDR_STATUS;
  logic mclk_i, rst_n_i, awvalid_i = 0, wvalid_i = 0, bready_i = 0, arvalid_i = 0;
  logic rready_i = 0, external_trigger_pin_i, fire = 0;
  logic [7:0] awaddr_i = 0, araddr_i = 0;
  logic [31:0] wdata_i = 0, rdata_o, d, v;
  logic [3:0] wstrb_i = 4'hf;
  logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, timer_output_pin_o;
  logic timer_output_pin_oe_o, compare_a_match_flag_o, period_match_flag_o;
  logic [1:0] bresp_o, rresp_o, r;
  int n_mismatch = 0, checks_done = 0, seed = 14, hi, pe, i;
  int cs[4][5] = '{'{1, 128, 0, 1, 0}, '{2, 64, 0, 0, 0}, '{1, 64, 0, 1, 1}, '{1, 767, 1, 1, 0}};
  standard_timer standard_timer_i (.*);
  trigger_source trigger_source_i (.mclk_i(mclk_i), .fire_i(fire), .pin_o(external_trigger_pin_i));
  initial begin
    mclk_i = 0;
    forever #5 mclk_i = ~mclk_i;
  end
  task stop_test;
    if (n_mismatch == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Handshakes are judged on values settled at the falling edge, acted on after the rising one.
  task wr(input logic [7:0] a, input logic [31:0] val);
    logic aw_go, w_go, b_go;
    @(posedge mclk_i);
    awaddr_i <= a;
    wdata_i <= val;
    awvalid_i <= 1'b1;
    wvalid_i <= 1'b1;
    bready_i <= 1'b1;
    b_go = 1'b0;
    while (!b_go) begin
      @(negedge mclk_i);
      aw_go = awvalid_i && (awready_o === 1'b1);
      w_go = wvalid_i && (wready_o === 1'b1);
      b_go = (bvalid_o === 1'b1);
      r = bresp_o;
      @(posedge mclk_i);
      if (aw_go) awvalid_i <= 1'b0;
      if (w_go) wvalid_i <= 1'b0;
    end
    bready_i <= 1'b0;
    @(negedge mclk_i);
  endtask : wr
  task rd(input logic [7:0] a);
    logic ar_go, r_go;
    @(posedge mclk_i);
    araddr_i <= a;
    arvalid_i <= 1'b1;
    rready_i <= 1'b1;
    r_go = 1'b0;
    while (!r_go) begin
      @(negedge mclk_i);
      ar_go = arvalid_i && (arready_o === 1'b1);
      r_go = (rvalid_o === 1'b1);
      d = rdata_o;
      r = rresp_o;
      @(posedge mclk_i);
      if (ar_go) arvalid_i <= 1'b0;
    end
    rready_i <= 1'b0;
    @(negedge mclk_i);
  endtask : rd
  function automatic logic [31:0] ctl(input logic [1:0] m, input logic [1:0] f, input logic [4:0] b);
    return {23'h0, b[4], m, f, b[3:0]};
  endfunction : ctl
  function automatic int model_hi(int per, int cmp, int dpx, int act_hi);
    int p, dd;
    p = (per == 0) ? 65536 : per * 256;
    dd = dpx ? p : cmp;
    if (!dpx && dd > p) dd = p;
    return act_hi ? dd : p - dd;
  endfunction : model_hi
  task meas;
    logic l, t;
    hi = 0;
    i = 0;
    @(negedge mclk_i);
    l = timer_output_pin_o;
    t = l;
    while (!(l && !t) && i < 3000) begin
      @(negedge mclk_i);
      t = l;
      l = timer_output_pin_o;
      i++;
    end
    do begin @(negedge mclk_i); hi++; end while (timer_output_pin_o && hi < 3000);
    pe = hi;
    do begin @(negedge mclk_i); pe++; end while (!timer_output_pin_o && pe < 3000);
  endtask : meas
  task waitc(input int n);
    repeat (n) @(negedge mclk_i);
  endtask : waitc
  initial begin
    repeat (60000) @(posedge mclk_i);
    n_mismatch++;
    stop_test();
  end
  initial begin
    rst_n_i = 0;
    repeat (10) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      rd(8'(k * 4));
      chk(d, 0);
      chk(r, std_timer_pkg::RESP_OKAY);
    end
    rd(8'h14);
    chk(d, 32'h0);
    chk(r, std_timer_pkg::RESP_SLVERR);
    wr(8'h06, 32'h1);
    chk(r, std_timer_pkg::RESP_SLVERR);
    repeat (3) begin
      v = $random(seed);
      wr(A_CMP, v);
      wr(A_PER, v);
      rd(A_CMP);
      chk(d, {16'h0, v[15:0]});
      rd(A_PER);
      chk(d, {24'h0, v[7:0]});
    end
    wr(A_PER, 1);
    wr(A_CMP, 600);
    wr(A_CTL, ctl(std_timer_pkg::MODE_COMPARE, std_timer_pkg::OUTFN_TOGGLE, 5'h11));
    i = 0;
    while (compare_a_match_flag_o !== 1'b1 && i < 2000) begin @(negedge mclk_i); i++; end
    waitc(3);
    chk(timer_output_pin_o, 1);
    chk(timer_output_pin_oe_o, 1);
    chk(period_match_flag_o, 0);
    rd(8'h0c);
    chk(d < 601, 1);
    wr(A_CTL, ctl(std_timer_pkg::MODE_COMPARE, std_timer_pkg::OUTFN_TOGGLE, 5'h01));
    wr(A_CTL, ctl(std_timer_pkg::MODE_COMPARE, std_timer_pkg::OUTFN_TOGGLE, 5'h11));
    waitc(3);
    chk(timer_output_pin_o, 0);
    wr(A_CTL, 0);
    wr(A_STS, 3);
    chk({compare_a_match_flag_o, period_match_flag_o}, 0);
    wr(A_CMP, 128);
    wr(A_CTL, ctl(std_timer_pkg::MODE_COMPARE, std_timer_pkg::OUTFN_TOGGLE, 5'h10));
    meas();
    chk(hi, 256);
    chk(pe, 512);
    chk({compare_a_match_flag_o, period_match_flag_o}, 2'h3);
    wr(A_CTL, 0);
    wr(A_STS, 3);
    wr(A_CTL, ctl(std_timer_pkg::MODE_TIMER, std_timer_pkg::OUTFN_TOGGLE, 5'h10));
    waitc(300);
    chk({timer_output_pin_oe_o, compare_a_match_flag_o, period_match_flag_o}, 3'h3);
    foreach (cs[k]) begin
      wr(A_CTL, 0);
      wr(A_PER, cs[k][0]);
      wr(A_CMP, cs[k][1]);
      wr(A_CTL, ctl(std_timer_pkg::MODE_PWM, std_timer_pkg::OUTFN_PWM,
                    {1'b1, 1'(cs[k][3]), 1'(cs[k][4]), 1'(cs[k][2]), 1'b1}));
      meas();
      chk(hi, model_hi(cs[k][0], cs[k][1], cs[k][2], cs[k][3] ^ cs[k][4]));
      if (cs[k][2] == 0) chk(pe, cs[k][0] * 256);
    end
    wr(A_CTL, 0);
    wr(A_CMP, 32'h150);
    wr(A_CTL, ctl(std_timer_pkg::MODE_PWM, std_timer_pkg::OUTFN_PWM, 5'h19));
    i = 0;
    repeat (600) begin @(negedge mclk_i); i += timer_output_pin_o; end
    chk(i, 600);
    wr(A_CTL, 0);
    wr(A_STS, 3);
    wr(A_CTL, ctl(std_timer_pkg::MODE_PWM, std_timer_pkg::OUTFN_ACT, 5'h18));
    waitc(300);
    chk({timer_output_pin_o, period_match_flag_o}, 2'h3);
    wr(A_CTL, 0);
    wr(A_CMP, 50);
    wr(A_CTL, ctl(std_timer_pkg::MODE_PWM, std_timer_pkg::OUTFN_PULSE, 5'h08));
    @(posedge mclk_i);
    fire <= 1'b1;
    @(posedge mclk_i);
    fire <= 1'b0;
    meas();
    chk(hi >= 49 && hi <= 52, 1);
    rd(A_CTL);
    chk(d[8], 0);
    wr(A_CTL, ctl(std_timer_pkg::MODE_PWM, std_timer_pkg::OUTFN_PULSE, 5'h18));
    waitc(5);
    chk(timer_output_pin_o, 1);
    wr(A_CTL, ctl(std_timer_pkg::MODE_PWM, std_timer_pkg::OUTFN_PULSE, 5'h08));
    waitc(3);
    chk(timer_output_pin_o, 0);
    stop_test();
  end
endmodule : standard_timer_tb
bind standard_timer standard_timer_assertions standard_timer_assertions_i (.*);
`default_nettype wire
